// ### core/memory_map_access_guard_map.vh
// Address map, section codes and constants for the memory map access guard
`ifndef MEMORY_MAP_ACCESS_GUARD_MAP_VH
`define MEMORY_MAP_ACCESS_GUARD_MAP_VH
`define MAG_IO_SHORT_END 16'h003f
`define MAG_IO_BIT_END 16'h001f
`define MAG_IO_EXT_END 16'h0fff
`define MAG_SCRATCH_BASE 16'h001c
`define MAG_EEPROM_BASE 16'h1400
`define MAG_EEPROM_SIZE 16'h0100
`define MAG_SETTINGS_BASE 16'h1300
`define MAG_SETTINGS_SIZE 16'h0020
`define MAG_SRAM_MIRROR_BASE 16'h2000
`define MAG_SRAM_MIRROR_END 16'h3fff
`define MAG_SRAM_SIZE 16'h0400
`define MAG_FLASH_DATA_BASE 16'h8000
`define MAG_FLASH_PM_BASE 16'h0000
`define MAG_SIG_LAST 8'h02
`define MAG_SCRATCH_RESET 8'h00
`define MAG_UNLOCK_VALUE 8'hc5
`define MAG_SEC_BOOT 2'h0
`define MAG_SEC_APPLICATION_CODE_SECTION 2'h1
`define MAG_SEC_APPLICATION_DATA_SECTION 2'h2
`define MAG_TGT_NONE 3'h0
`define MAG_TGT_IO 3'h1
`define MAG_TGT_EEPROM 3'h2
`define MAG_TGT_SETTINGS 3'h3
`define MAG_TGT_SRAM 3'h4
`define MAG_TGT_FLASH 3'h5
`define MAG_DBG_FLASH 3'h0
`define MAG_DBG_SRAM 3'h1
`define MAG_DBG_EEPROM 3'h2
`define MAG_DBG_FUSE 3'h3
`define MAG_DBG_SETTINGS 3'h4
`define MAG_DBG_SIG 3'h5
`define MAG_DBG_INFO 3'h6
`define MAG_DBG_REGS 3'h7
`endif

// ### core/memory_map_access_guard.v
// Data-space decoder, self-programming rights, scratch bytes and debug-port gating
// Notes on behaviour
// - Whole 0x2000..0x3FFF window decodes to SRAM, mirrored.
// - A Flash section may never program itself.
// - Code in application data section cannot write Flash or EEPROM.
// - CPU stalls while a self-programming operation is busy.
// - EEPROM writes from boot or application code are accepted.
// - Flash appears in data space from 0x8000 for load/store.
// - Program-memory load addresses Flash from offset 0x0000.
// - EEPROM takes single-byte reads and writes, no page needed.
// - Debug port may write firmware settings page while locked.
// - Full chip erase leaves firmware settings page intact.
// - Three identification bytes live at 0x00..0x02 of a separate space.
// - Locked debug reads return only the system info block.
// - Short I/O range 0x00..0x3F completes in one cycle.
// - Extended I/O 0x0040..0x0FFF reachable only by general load/store.
// - Bit set, clear and skip tests only on I/O 0x00..0x1F.
// - Bit set/clear touches only the addressed bit.
// - Four 8-bit bit-addressable scratch bytes at 0x1C..0x1F, reset zero.
// - Any lock field value other than the unlock value locks.
// - Locked: debug reads of memories and fuses denied; CPU unaffected.
// - Denied read completes silently with invalid data.
// - Locked: settings page writable blind, never read back.
// - A full chip erase or a lock field holding the unlock value unlocks.
`include "memory_map_access_guard_map.vh"
`timescale 1ns/10ps
`default_nettype none
module memory_map_access_guard #(
  parameter [7:0] SIG_BYTE0 = 8'h5a,
  parameter [7:0] SIG_BYTE1 = 8'h3c,
  parameter [7:0] SIG_BYTE2 = 8'h0f,
  parameter [15:0] SRAM_SIZE = `MAG_SRAM_SIZE
) (
  input wire clk,
  input wire rst,
  input wire cpu_req,
  input wire cpu_we,
  input wire cpu_pm_load,
  input wire cpu_short_io,
  input wire [1:0] cpu_bit_op,
  input wire [2:0] cpu_bit_sel,
  input wire [15:0] cpu_addr,
  input wire [7:0] cpu_wdata,
  input wire [1:0] cpu_exec_section,
  input wire [15:0] boot_section_end,
  input wire [15:0] application_code_section_section_end,
  input wire nvm_prog_req,
  input wire [15:0] nvm_prog_addr,
  input wire nvm_busy,
  input wire [7:0] lock_field,
  input wire full_chip_erase,
  input wire dbg_req,
  input wire dbg_we,
  input wire [2:0] dbg_space,
  input wire [7:0] dbg_addr,
  input wire [7:0] dbg_mem_rdata,
  input wire [7:0] dbg_info_rdata,
  output reg [2:0] cpu_target,
  output reg [15:0] cpu_phys_addr,
  output reg cpu_addr_fault,
  output wire cpu_stall,
  output reg [7:0] scratch_rdata,
  output reg scratch_hit,
  output reg skip_taken,
  output wire prog_allowed,
  output wire locked,
  output reg dbg_mem_we,
  output reg dbg_ack,
  output reg [7:0] dbg_rdata,
  output reg dbg_rdata_valid,
  output reg erase_start
);
  reg [7:0] scratch_q [0:3];
  reg lock_q;
  reg lock_d;
  reg [15:0] off;
  reg [1:0] tgt_sec;
  reg wr_ok;
  reg is_nv;
  wire [1:0] sidx;
  wire sel_scr;
  wire bit_ok;
  wire [15:0] scr_base;
  wire op_set;
  wire op_clr;
  wire op_skip;
  wire op_none;
  integer i;
  localparam [1:0] BIT_OP_NONE = 2'h0;
  localparam [1:0] BIT_OP_SET = 2'h1;
  localparam [1:0] BIT_OP_CLR = 2'h2;
  localparam [1:0] BIT_OP_SKIP = 2'h3;

  // Lock is taken from the fuse field each cycle; the erase drops it at the next clock edge
  always @*
  begin
    lock_d = (lock_field != `MAG_UNLOCK_VALUE);
    if (full_chip_erase)
      lock_d = 1'b0;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      lock_q <= 1'b1;
    else
      lock_q <= lock_d;
  end
  assign locked = lock_q;

  // CPU data-space decode
  always @*
  begin
    cpu_target = `MAG_TGT_NONE;
    cpu_phys_addr = 16'h0000;
    cpu_addr_fault = 1'b0;
    if (cpu_req)
    begin
      if (cpu_pm_load)
      begin
        cpu_target = `MAG_TGT_FLASH;
        cpu_phys_addr = cpu_addr - `MAG_FLASH_PM_BASE;
      end
      else if (cpu_short_io)
      begin
        cpu_target = `MAG_TGT_IO;
        cpu_phys_addr = {10'h000, cpu_addr[5:0]};
        cpu_addr_fault = (cpu_addr > `MAG_IO_SHORT_END);
      end
      else if (cpu_addr >= `MAG_FLASH_DATA_BASE)
      begin
        cpu_target = `MAG_TGT_FLASH;
        cpu_phys_addr = cpu_addr - `MAG_FLASH_DATA_BASE;
      end
      else if (cpu_addr >= `MAG_SRAM_MIRROR_BASE && cpu_addr <= `MAG_SRAM_MIRROR_END)
      begin
        cpu_target = `MAG_TGT_SRAM;
        // Power-of-two size assumed, so masking gives the mirror
        cpu_phys_addr = cpu_addr & (SRAM_SIZE - 16'h0001);
      end
      else if (cpu_addr >= `MAG_EEPROM_BASE &&
               cpu_addr < `MAG_EEPROM_BASE + `MAG_EEPROM_SIZE)
      begin
        cpu_target = `MAG_TGT_EEPROM;
        cpu_phys_addr = cpu_addr - `MAG_EEPROM_BASE;
      end
      else if (cpu_addr >= `MAG_SETTINGS_BASE &&
               cpu_addr < `MAG_SETTINGS_BASE + `MAG_SETTINGS_SIZE)
      begin
        cpu_target = `MAG_TGT_SETTINGS;
        cpu_phys_addr = cpu_addr - `MAG_SETTINGS_BASE;
      end
      else if (cpu_addr <= `MAG_IO_EXT_END)
      begin
        cpu_target = `MAG_TGT_IO;
        cpu_phys_addr = cpu_addr;
      end
      else
        cpu_addr_fault = 1'b1;
    end
  end

  // Self-programming rights by section of the executing code and the target
  always @*
  begin
    off = nvm_prog_addr - `MAG_FLASH_DATA_BASE;
    is_nv = 1'b1;
    tgt_sec = `MAG_SEC_APPLICATION_DATA_SECTION;
    if (nvm_prog_addr >= `MAG_FLASH_DATA_BASE)
    begin
      if (off < boot_section_end)
        tgt_sec = `MAG_SEC_BOOT;
      else if (off < application_code_section_section_end)
        tgt_sec = `MAG_SEC_APPLICATION_CODE_SECTION;
    end
    else
      is_nv = 1'b0;
    wr_ok = 1'b0;
    if (cpu_exec_section == `MAG_SEC_APPLICATION_DATA_SECTION)
      wr_ok = 1'b0;
    else if (!is_nv)
      wr_ok = 1'b1;
    else if (cpu_exec_section == `MAG_SEC_BOOT)
      wr_ok = (tgt_sec != `MAG_SEC_BOOT);
    else
      wr_ok = (tgt_sec == `MAG_SEC_APPLICATION_DATA_SECTION);
  end
  assign prog_allowed = nvm_prog_req && wr_ok;
  // Stalling for the whole busy time avoids fetching from a Flash being rewritten
  assign cpu_stall = nvm_busy;

  // Scratch bytes, reached as short I/O; bit ops limited to the low I/O range
  assign sidx = cpu_addr[1:0];
  assign scr_base = `MAG_SCRATCH_BASE;
  // Program-memory loads address Flash, so they must never hit the scratch bytes
  assign sel_scr = cpu_req && !cpu_pm_load &&
                   (cpu_short_io || cpu_addr <= `MAG_IO_SHORT_END) &&
                   (cpu_addr[15:2] == scr_base[15:2]);
  assign bit_ok = (cpu_addr <= `MAG_IO_BIT_END);
  assign op_none = (cpu_bit_op == BIT_OP_NONE);
  assign op_set = (cpu_bit_op == BIT_OP_SET) && bit_ok;
  assign op_clr = (cpu_bit_op == BIT_OP_CLR) && bit_ok;
  assign op_skip = (cpu_bit_op == BIT_OP_SKIP) && bit_ok;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (i = 0; i < 4; i = i + 1)
        scratch_q[i] <= `MAG_SCRATCH_RESET;
    end
    else if (sel_scr)
    begin
      if (op_set)
        scratch_q[sidx][cpu_bit_sel] <= 1'b1;
      else if (op_clr)
        scratch_q[sidx][cpu_bit_sel] <= 1'b0;
      else if (op_none && cpu_we)
        scratch_q[sidx] <= cpu_wdata;
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scratch_rdata <= 8'h00;
      scratch_hit <= 1'b0;
      skip_taken <= 1'b0;
    end
    else
    begin
      scratch_hit <= sel_scr;
      scratch_rdata <= sel_scr ? scratch_q[sidx] : 8'h00;
      // Bit op 3 is the skip test; bit_sel picks the bit, cpu_wdata[0] the sense
      skip_taken <= sel_scr && op_skip &&
                    (scratch_q[sidx][cpu_bit_sel] == cpu_wdata[0]);
    end
  end

  // Debug port gating; denied reads still ack, with zero data flagged invalid
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dbg_ack <= 1'b0;
      dbg_rdata <= 8'h00;
      dbg_rdata_valid <= 1'b0;
      dbg_mem_we <= 1'b0;
      erase_start <= 1'b0;
    end
    else
    begin
      dbg_ack <= dbg_req;
      dbg_rdata <= 8'h00;
      dbg_rdata_valid <= 1'b0;
      dbg_mem_we <= 1'b0;
      erase_start <= full_chip_erase;
      if (dbg_req && !dbg_we)
      begin
        if (dbg_space == `MAG_DBG_INFO)
        begin
          dbg_rdata <= dbg_info_rdata;
          dbg_rdata_valid <= 1'b1;
        end
        else if (lock_q)
          dbg_rdata_valid <= 1'b0;
        else if (dbg_space == `MAG_DBG_SIG)
        begin
          dbg_rdata_valid <= (dbg_addr <= `MAG_SIG_LAST);
          case (dbg_addr)
            8'h00: dbg_rdata <= SIG_BYTE0;
            8'h01: dbg_rdata <= SIG_BYTE1;
            8'h02: dbg_rdata <= SIG_BYTE2;
            default: dbg_rdata <= 8'h00;
          endcase
        end
        else
        begin
          dbg_rdata <= dbg_mem_rdata;
          dbg_rdata_valid <= 1'b1;
        end
      end
      else if (dbg_req && dbg_we)
      begin
        if (dbg_space == `MAG_DBG_SETTINGS)
          dbg_mem_we <= 1'b1;
        else if (dbg_space == `MAG_DBG_SIG || dbg_space == `MAG_DBG_INFO)
          dbg_mem_we <= 1'b0;
        else
          dbg_mem_we <= !lock_q;
      end
    end
  end
endmodule // memory_map_access_guard
`default_nettype wire

// ### dv/guard_sva.sv
// Port assertions for the memory map access guard
`timescale 1ns/10ps
`default_nettype none
module guard_sva #(
  parameter logic [7:0] SIG_BYTE0 = 8'h5a // Arbitrary value
) (
  input wire logic clk, rst, cpu_req, cpu_pm_load, nvm_prog_req, nvm_busy,
  input wire logic full_chip_erase, dbg_req, dbg_we, cpu_stall, scratch_hit,
  input wire logic prog_allowed, locked, dbg_mem_we, dbg_ack, dbg_rdata_valid,
  input wire logic erase_start,
  input wire logic [1:0] cpu_exec_section,
  input wire logic [2:0] dbg_space, cpu_target,
  input wire logic [7:0] lock_field, dbg_addr, dbg_rdata,
  input wire logic [15:0] cpu_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence sig_rd;
    !locked && dbg_req && !dbg_we && dbg_space == 3'h5 && dbg_addr == 8'h00;
  endsequence
  sequence lock_rd;
    locked && dbg_req && !dbg_we && dbg_space != 3'h6;
  endsequence
  a_stall_tracks_busy: assert property (cpu_stall == nvm_busy)
    else $error("stall differs from busy");
  a_mirror_to_sram: assert property (cpu_req && !cpu_pm_load && cpu_addr[15:13] == 3'h1
    |-> cpu_target == 3'h4) else $error("mirror window not sram");
  a_flash_data_map: assert property (cpu_req && !cpu_pm_load && cpu_addr[15]
    |-> cpu_target == 3'h5) else $error("upper half not flash");
  a_pm_load_flash: assert property (cpu_req && cpu_pm_load |-> cpu_target == 3'h5)
    else $error("pm load not flash");
  a_locked_read_deny: assert property (lock_rd |=> dbg_ack && !dbg_rdata_valid
    && dbg_rdata == 8'h00) else $error("locked read leaked");
  a_sig_byte_zero: assert property (sig_rd |=> dbg_rdata_valid && dbg_rdata == SIG_BYTE0)
    else $error("id byte wrong");
  a_lock_invalid: assert property ((lock_field != 8'hc5 && !full_chip_erase)[*2] |-> locked)
    else $error("not locked");
  a_blind_settings: assert property (locked && dbg_req && dbg_we && dbg_space == 3'h4
    |=> dbg_mem_we && dbg_ack) else $error("settings write refused");
  a_application_data_section_no_prog: assert property (nvm_prog_req && cpu_exec_section == 2'h2
    |-> !prog_allowed) else $error("application_data_section programmed");
  a_scratch_hit: assert property (cpu_req && !cpu_pm_load && cpu_addr[15:2] == 14'h0007
    |=> scratch_hit) else $error("scratch missed");
  a_erase_pulse: assert property ($rose(full_chip_erase) |=> erase_start)
    else $error("erase not started");
endmodule // guard_sva
`default_nettype wire

// ### dv/debug_host_model.sv
// Debug host model on the far side of the debug port
`timescale 1ns/10ps
`default_nettype none
module debug_host_model #(
  parameter logic [7:0] INFO = 8'h3a
) (
  input wire logic go, we,
  input wire logic [2:0] space,
  input wire logic [7:0] addr,
  output logic dbg_req, dbg_we,
  output logic [2:0] dbg_space,
  output logic [7:0] dbg_addr, dbg_mem_rdata, dbg_info_rdata
);
  // Idle space and address lines carry inverted junk, and req and we stay low, so a stale request never looks valid
  assign dbg_req = go;
  assign dbg_we = go & we;
  assign dbg_space = go ? space : ~space;
  assign dbg_addr = go ? addr : ~addr;
  // Memory data is non-zero so a leaked locked read shows up
  assign dbg_mem_rdata = 8'ha5;
  assign dbg_info_rdata = INFO;
endmodule // debug_host_model
`default_nettype wire

// ### dv/tb_memory_map_access_guard.sv
// Self-checking bench for the memory map access guard
`timescale 1ns/10ps
`default_nettype none
module tb_memory_map_access_guard;
  logic clk = 0, rst = 1, cpu_req = 0, cpu_we = 0, cpu_pm_load = 0, cpu_short_io = 0;
  logic nvm_prog_req = 0, nvm_busy = 0, full_chip_erase = 0, go = 0, we = 0;
  logic [1:0] cpu_bit_op = '0, cpu_exec_section = '0;
  logic [2:0] cpu_bit_sel = '0, space = '0, cpu_target, dbg_space;
  logic [15:0] cpu_addr = '0, nvm_prog_addr = '0, cpu_phys_addr;
  logic [15:0] boot_section_end = 16'h0100, application_code_section_section_end = 16'h0200;
  logic [7:0] cpu_wdata = '0, lock_field = 8'hc5, addr = '0, scratch_rdata, dbg_rdata;
  logic [7:0] dbg_addr, dbg_mem_rdata, dbg_info_rdata;
  logic cpu_addr_fault, cpu_stall, scratch_hit, skip_taken, prog_allowed, locked;
  logic dbg_mem_we, dbg_ack, dbg_rdata_valid, erase_start, dbg_req, dbg_we;
  int miscompares = 0, compares = 0;
  // Arbitrary id values
  logic [7:0] sig[3] = '{8'h11, 8'h22, 8'h33};
  logic [15:0] da[7] = '{16'h2000, 16'h3fff, 16'h8000, 16'h1400, 16'h0000, 16'h1000, 16'h0040};
  logic [2:0] dt[7] = '{3'h4, 3'h4, 3'h5, 3'h2, 3'h5, 3'h0, 3'h1};
  logic [15:0] dp[7] = '{16'h0000, 16'h03ff, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0040};
  logic [1:0] ps[7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h0, 2'h2};
  logic [15:0] pa[7] = '{16'h8150, 16'h8010, 16'h8250, 16'h8150, 16'h8250, 16'h1400, 16'h1400};
  logic pe[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  memory_map_access_guard #(.SIG_BYTE0(8'h11), .SIG_BYTE1(8'h22), .SIG_BYTE2(8'h33))
    i_memory_map_access_guard (.*);
  debug_host_model #(.INFO(8'h3a)) i_debug_host_model (.go, .we, .space, .addr, .dbg_req,
    .dbg_we, .dbg_space, .dbg_addr, .dbg_mem_rdata, .dbg_info_rdata);
  initial
  begin
    forever #25 clk = ~clk;
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cpu(logic w, logic [1:0] op, logic [2:0] sel, logic [15:0] a, logic [7:0] d);
    cpu_req = 1; cpu_we = w; cpu_bit_op = op; cpu_bit_sel = sel; cpu_addr = a; cpu_wdata = d;
    cpu_short_io = a < 16'h0040;
    @(negedge clk);
  endtask
  task automatic dbg(logic w, logic [2:0] s, logic [7:0] a);
    go = 1; we = w; space = s; addr = a;
    @(negedge clk);
  endtask
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #100000 miscompares++;
    finish_test();
  end
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 4; i++)
    begin
      cpu(0, 2'h0, 3'h0, 16'h001c + 16'(i), 8'h00);
      check("scratch reset", scratch_rdata, 16'h0000);
    end
    cpu(1, 2'h0, 3'h0, 16'h001f, 8'h55);
    cpu(0, 2'h1, 3'h1, 16'h001f, 8'h00);
    cpu(0, 2'h2, 3'h0, 16'h001f, 8'h00);
    cpu(0, 2'h0, 3'h0, 16'h001f, 8'h00);
    check("bit set clear", scratch_rdata, 16'h0056);
    cpu(0, 2'h3, 3'h1, 16'h001f, 8'h01);
    check("skip set", skip_taken, 16'h0001);
    cpu(0, 2'h3, 3'h0, 16'h001f, 8'h01);
    check("skip clear", skip_taken, 16'h0000);
    foreach (da[i])
    begin
      cpu_req = 1; cpu_we = 0; cpu_short_io = 0; cpu_bit_op = 2'h0; cpu_addr = da[i];
      cpu_pm_load = (i == 4);
      #1 check("target", cpu_target, 16'(dt[i]));
      check("phys addr", cpu_phys_addr, dp[i]);
      check("addr fault", cpu_addr_fault, 16'(i == 5));
      @(negedge clk);
    end
    cpu_req = 0; cpu_pm_load = 0;
    foreach (ps[i])
    begin
      nvm_prog_req = 1; cpu_exec_section = ps[i]; nvm_prog_addr = pa[i];
      #1 check("prog rights", prog_allowed, 16'(pe[i]));
      @(negedge clk);
    end
    nvm_prog_req = 0; nvm_busy = 1;
    #1 check("stall", cpu_stall, 16'h0001);
    @(negedge clk) nvm_busy = 0;
    for (int i = 0; i < 3; i++)
    begin
      dbg(0, 3'h5, 8'(i));
      check("id byte", dbg_rdata, 16'(sig[i]));
    end
    lock_field = 8'h00;
    @(negedge clk) check("locked", locked, 16'h0001);
    dbg(0, 3'h5, 8'h00);
    check("locked id valid", dbg_rdata_valid, 16'h0000);
    dbg(0, 3'h4, 8'h00);
    check("settings readback", dbg_rdata_valid, 16'h0000);
    check("denied ack", dbg_ack, 16'h0001);
    dbg(0, 3'h6, 8'h00);
    check("info block", dbg_rdata, 16'h003a);
    dbg(1, 3'h4, 8'h00);
    check("settings write", dbg_mem_we, 16'h0001);
    dbg(1, 3'h0, 8'h00);
    check("flash write", dbg_mem_we, 16'h0000);
    go = 0;
    cpu(1, 2'h0, 3'h0, 16'h001c, 8'haa);
    cpu(0, 2'h0, 3'h0, 16'h001c, 8'h00);
    check("cpu while locked", scratch_rdata, 16'h00aa);
    full_chip_erase = 1;
    @(negedge clk) check("erase start", erase_start, 16'h0001);
    check("erase unlock", locked, 16'h0000);
    full_chip_erase = 0;
    @(negedge clk) finish_test();
  end
endmodule // tb_memory_map_access_guard
bind memory_map_access_guard guard_sva #(.SIG_BYTE0(SIG_BYTE0)) i_guard_sva (.*);
`default_nettype wire
